// ---- core/datalink_hdlc_tx_control.sv ----
// transmit control for the third data-link hdlc controller, apb register slave
// assumes dl_slot pulses once per data-link bit time on the same clock
//
// Contract
// - forced idle in message mode sends only flags
// - no frame waiting means flags are sent
// - forced idle ignored in bit-oriented mode
// - checksum append adds fcs, else omitted
// - checksum append ignored in bit-oriented mode
// - type bit: 0 bit-oriented, 1 message frame
// - buffer select write sends chosen buffer
// - buffer select read gives free buffer
// - busy buffer makes readback show the other
// - repeat count reached raises end-of-transfer, stops
// - zero repeat count repeats until a new bit-oriented command
// - message mode count is frame length
// - abort command sends seven or more ones
`timescale 1ns/1ps
module datalink_hdlc_tx_control
  import dl_tx_pkg::*;
#(
  parameter int BUF_WORDS = 32 // words per message buffer
) (
  input  wire logic              pclk,                   // 25 MHz clock
  input  wire logic              presetn,                // async reset, active low
  input  wire logic              psel,                   // apb select
  input  wire logic              penable,                // apb access phase
  input  wire logic              pwrite,                 // apb write
  input  wire logic [ADDR_W-1:0] paddr,                  // apb byte address
  input  wire logic [DATA_W-1:0] pwdata,                 // apb write data
  output logic      [DATA_W-1:0] prdata,                 // apb read data
  output logic                   pready,                 // apb ready
  output logic                   pslverr,                // apb error
  input  wire logic              dl_slot,                // data-link bit time strobe
  output logic                   dl_bit,                 // data-link bit out
  output logic                   tx_end_of_transfer_irq  // end-of-transfer pulse
);
  localparam int MAW = $clog2(2 * BUF_WORDS);            // store address width
  if (BUF_WORDS * 4 < (1 << CNT_W) - 1 || BUF_WORDS > (1 << (BUF_SEL_POS - WORD_LSB))) begin : g_chk
    $error("buffer size cannot hold the longest message or overlaps");
  end

  typedef struct packed {
    logic [7:0]        ctrl;      // control register
    logic [CNT_W-1:0]  count;     // length or repeat count
    logic              sel;       // last selected buffer
    logic [1:0]        inuse;     // buffers not yet consumed
    logic              cmd_mos;   // frame send pending
    logic              cmd_bos;   // bit-oriented send pending
    logic              pend_buf;  // buffer of pending command
    logic [DATA_W-1:0] prdata;    // read data
    logic              pready;    // ready
    logic              pslverr;   // error
    prod_state_t       pst;       // producer state
    logic              cur_buf;   // buffer being sent
    logic [CNT_W-1:0]  idx;       // byte index
    logic [CNT_W-1:0]  len;       // latched length or repeats
    logic [CNT_W-1:0]  reps;      // repetitions done
    logic              fetched;   // store data valid for idx
    logic              frame_fcs; // fcs wanted for this frame
    logic [15:0]       crc;       // running fcs
    logic [1:0][8:0]   fifo;      // {stuff, octet} entries
    logic [1:0]        fcnt;      // entries held
    logic [7:0]        shreg;     // serialiser shift
    logic [3:0]        bitcnt;    // bits left in shreg
    logic [2:0]        ones;      // run of ones in frame
    logic              dl_bit;    // line bit
    logic              eot;       // end pulse
  } ctl_state_t;
  ctl_state_t r, next_r;
  msg_mem_if #(.AW(MAW), .DW(DATA_W)) mem ();
  msg_mem #(.AW(MAW), .DW(DATA_W), .DEPTH(2 * BUF_WORDS)) u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .mem     (mem)
  );
  logic       setup;      // apb setup cycle
  logic       wr_go;      // write takes effect
  logic       in_win;     // address in buffer window
  logic       mos_mode;   // message mode selected
  logic       idle_force; // forced idle effective
  logic       fcs_on;     // fcs append effective
  logic       free_buf;   // buffer readback
  logic       fifo_rdy;   // buffer can take an octet
  logic       push;       // producer writes an octet
  logic [8:0] push_oct;   // octet written
  logic       pop;        // serialiser takes the head
  logic [7:0] mem_byte;   // octet picked from the word
  logic [8:0] load;       // octet entering shreg
  logic       out_b;      // bit sent this slot
  // mode decode and window decode
  always_comb begin
    setup      = psel && !penable;
    wr_go      = psel && penable && r.pready && pwrite;
    in_win     = paddr[ADDR_W-1:WIN_LSB] == BUF_WIN &&
                 32'(paddr[BUF_SEL_POS-1:WORD_LSB]) < BUF_WORDS;
    mos_mode   = r.ctrl[SIG_POS];
    idle_force = r.ctrl[IDLE_POS] && mos_mode;
    fcs_on     = r.ctrl[FCS_POS] && mos_mode;
    free_buf   = r.inuse[0];
    fifo_rdy   = r.fcnt != FIFO_DEPTH;
    mem_byte   = mem.rdata[8*r.idx[1:0] +: 8];
  end
  // buffer writes go straight to the store; reads of it answer zero
  assign mem.we    = wr_go && in_win;
  assign mem.waddr = {paddr[BUF_SEL_POS], paddr[WORD_LSB +: MAW-1]}; // buffer bit kept on top of the word index
  assign mem.wdata = pwdata;
  assign mem.raddr = MAW'({r.cur_buf, r.idx[CNT_W-1:WORD_LSB]});
  // registers, producer, two-entry buffer and serialiser
  always_comb begin
    next_r     = r;
    next_r.eot = 1'b0;
    push       = 1'b0;
    push_oct   = {1'b0, FLAG_OCTET};
    pop        = 1'b0;
    load       = {1'b0, FLAG_OCTET};
    out_b      = 1'b1;
    // apb answer is prepared in setup, so access always lasts one cycle
    next_r.pready = setup;
    if (setup) begin
      next_r.pslverr = 1'b0;
      next_r.prdata  = '0;
      if (paddr == CTRL_OFF) begin
        next_r.prdata[7:0] = r.ctrl;
      end else if (paddr == LENBUF_OFF) begin
        next_r.prdata[7:0] = {free_buf, r.count};
      end else if (!in_win) begin
        next_r.pslverr = 1'b1;                                 // unmapped
      end
    end
    // producer: flags when nothing waits, frames, or repeated messages
    case (r.pst)
      P_IDLE: begin
        if (r.cmd_bos) begin
          next_r.cmd_bos = 1'b0;
          next_r.cur_buf = r.pend_buf;
          next_r.idx     = '0;
          next_r.reps    = '0;
          next_r.len     = r.count;
          next_r.fetched = 1'b0;
          next_r.pst     = P_BOS_HI;
        end else if (r.cmd_mos && idle_force) begin
          next_r.cmd_mos = 1'b0;
          next_r.inuse[r.pend_buf] = 1'b0;
        end else if (r.cmd_mos) begin
          next_r.cmd_mos   = 1'b0;
          next_r.cur_buf   = r.pend_buf;
          next_r.idx       = '0;
          next_r.len       = r.count;
          next_r.crc       = CRC_INIT;
          next_r.frame_fcs = fcs_on;
          next_r.fetched   = 1'b0;
          next_r.pst       = P_OPEN;
        end else if (fifo_rdy) begin
          push = 1'b1;
        end
      end
      P_OPEN: begin
        if (fifo_rdy) begin
          push       = 1'b1;
          next_r.pst = P_DATA;
        end
      end
      P_DATA: begin
        if (idle_force) begin
          next_r.inuse[r.cur_buf] = 1'b0;
          next_r.pst = P_IDLE;
        end else if (r.idx == r.len) begin
          next_r.inuse[r.cur_buf] = 1'b0;
          next_r.pst = r.frame_fcs ? P_FCS_LO : P_IDLE;
          next_r.eot = !r.frame_fcs;
        end else if (!r.fetched) begin
          next_r.fetched = 1'b1;                               // store latency
        end else if (fifo_rdy) begin
          push           = 1'b1;
          push_oct       = {1'b1, mem_byte};
          next_r.crc     = crc_byte(r.crc, mem_byte);
          next_r.idx     = r.idx + 1'b1;
          next_r.fetched = 1'b0;
        end
      end
      P_FCS_LO: begin
        if (fifo_rdy) begin
          push       = 1'b1;
          push_oct   = {1'b1, ~r.crc[7:0]};
          next_r.pst = P_FCS_HI;
        end
      end
      P_FCS_HI: begin
        if (fifo_rdy) begin
          push       = 1'b1;
          push_oct   = {1'b1, ~r.crc[15:8]};
          next_r.pst = P_IDLE;
          next_r.eot = 1'b1;
        end
      end
      P_BOS_HI: begin
        if (!r.fetched) begin
          next_r.fetched = 1'b1;
        end else if (fifo_rdy) begin
          push       = 1'b1;
          push_oct   = {1'b0, mem.rdata[7:0]};
          next_r.pst = P_BOS_LO;
        end
      end
      P_BOS_LO: begin
        if (fifo_rdy) begin
          push        = 1'b1;
          push_oct    = {1'b0, mem.rdata[15:8]};
          next_r.reps = r.reps + 1'b1;
          next_r.pst  = P_BOS_HI;
          // a zero count never ends; a new bit-oriented command ends an endless run
          if ((r.len != '0 && r.reps + 1'b1 == r.len) || (r.len == '0 && r.cmd_bos)) begin
            next_r.inuse[r.cur_buf] = 1'b0;
            next_r.pst = P_IDLE;
            next_r.eot = r.len != '0;
          end
        end
      end
      default: next_r.pst = P_IDLE;
    endcase
    // serialiser: one bit per slot, stuffing and abort decided here
    if (dl_slot) begin
      if (r.ctrl[ABORT_POS]) begin
        out_b       = 1'b1;
        next_r.ones = '0;
      end else if (r.ones == STUFF_RUN) begin
        out_b       = 1'b0;
        next_r.ones = '0;
      end else begin
        if (r.bitcnt == '0) begin
          pop = r.fcnt != '0;
          if (pop) begin
            load = r.fifo[0];
          end
          out_b         = load[0];
          next_r.shreg  = {load[8], load[7:1]};
          next_r.bitcnt = LAST_BIT;
          next_r.ones   = (load[8] && out_b) ? 3'(r.ones + 1'b1) : 3'h0; // a run carries across octets
        end else begin
          out_b         = r.shreg[0];
          next_r.shreg  = {r.shreg[7], 1'b0, r.shreg[6:1]};
          next_r.bitcnt = r.bitcnt - 1'b1;
          next_r.ones   = (r.shreg[7] && out_b) ? r.ones + 1'b1 : 3'h0;
        end
      end
      next_r.dl_bit = out_b;
    end
    // two-entry buffer: head at slot 0, a pop shifts before the push lands
    if (pop) begin
      next_r.fifo[0] = r.fifo[1];
    end
    if (push) begin
      next_r.fifo[r.fcnt - {1'b0, pop}] = push_oct;
    end
    next_r.fcnt = r.fcnt + {1'b0, push} - {1'b0, pop};
    // register writes come last so a command set beats a producer clear
    if (wr_go && paddr == CTRL_OFF) begin
      next_r.ctrl = pwdata[7:0] & CTRL_MASK;
      if (!pwdata[SIG_POS]) begin
        next_r.cmd_bos  = 1'b1;
        next_r.pend_buf = r.sel;
        next_r.inuse[r.sel] = 1'b1;
      end
    end
    if (wr_go && paddr == LENBUF_OFF) begin
      next_r.count = pwdata[CNT_W-1:0];
      next_r.sel   = pwdata[SEL_POS];
      if (mos_mode) begin
        next_r.cmd_mos  = 1'b1;
        next_r.pend_buf = pwdata[SEL_POS];
        next_r.inuse[pwdata[SEL_POS]] = 1'b1;
      end
    end
  end

  // single state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r        <= '0;
      r.ctrl   <= CTRL_RESET;
      r.count  <= COUNT_RESET;
      r.pst    <= P_IDLE;
      r.dl_bit <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign prdata                 = r.prdata;
  assign pready                 = r.pready;
  assign pslverr                = r.pslverr;
  assign dl_bit                 = r.dl_bit;
  assign tx_end_of_transfer_irq = r.eot;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_slot_abort;
    dl_slot && r.ctrl[ABORT_POS];
  endsequence
  sequence s_five_ones;
    dl_slot && !r.ctrl[ABORT_POS] && r.ones == STUFF_RUN;
  endsequence
  AST_IDLE_OVERRIDES: assert property ((r.pst == P_DATA && idle_force) |=> r.pst == P_IDLE)
    else $error("forced idle did not end the frame");
  AST_IDLE_FLAGS: assert property ((r.pst == P_IDLE && push) |-> push_oct == {1'b0, FLAG_OCTET})
    else $error("idle producer pushed a non-flag");
  AST_BOS_KEEPS_GOING: assert property ((r.pst == P_BOS_HI && !mos_mode && r.ctrl[IDLE_POS]) |=>
                                        r.pst inside {P_BOS_HI, P_BOS_LO})
    else $error("forced idle disturbed bit-oriented send");
  AST_FCS_FOLLOWS: assert property ((r.pst == P_DATA && r.idx == r.len && r.frame_fcs && !idle_force) |=>
                                    r.pst == P_FCS_LO)
    else $error("fcs octets not sent");
  AST_FCS_HI_NEXT: assert property ((r.pst == P_FCS_LO && fifo_rdy) |=> r.pst == P_FCS_HI)
    else $error("high fcs octet not queued after the low one");
  AST_BOS_NO_FCS: assert property (r.pst inside {P_BOS_HI, P_BOS_LO} |=> r.pst != P_FCS_LO)
    else $error("fcs in bit-oriented mode");
  AST_SEND_CMD: assert property ((wr_go && paddr == LENBUF_OFF && mos_mode) |=>
                                 r.cmd_mos && r.pend_buf == $past(pwdata[SEL_POS]) && r.inuse[r.pend_buf])
    else $error("buffer select write did not queue the frame");
  AST_FREE_READ: assert property ((setup && paddr == LENBUF_OFF) |=> r.prdata[SEL_POS] == $past(r.inuse[0]))
    else $error("free buffer readback wrong");
  AST_BOS_EOT: assert property ((r.pst == P_BOS_LO && push && r.len != '0 && r.reps + 1'b1 == r.len) |=>
                                r.eot && r.pst == P_IDLE)
    else $error("repeat count end missed");
  AST_ENDLESS: assert property ((r.pst == P_BOS_LO && r.len == '0) |=> !r.eot)
    else $error("endless repeat raised end of transfer");
  AST_ABORT_ONES: assert property (s_slot_abort |=> dl_bit)
    else $error("abort did not send a one");
  AST_STUFF_ZERO: assert property (s_five_ones |=> !dl_bit && r.ones == '0)
    else $error("no zero after five ones");
endmodule : datalink_hdlc_tx_control

// ---- core/dl_tx_pkg.sv ----
// constants, types and helpers for the data-link transmit controller
// assumes a 12-bit apb byte address and 8-bit documented registers
package dl_tx_pkg;
  localparam int          ADDR_W       = 12;             // apb byte address width
  localparam int          DATA_W       = 32;             // apb data width
  localparam int          CNT_W        = 7;              // length or repeat field width
  localparam logic [11:0] CTRL_OFF     = 12'h150;        // transmit control register
  localparam logic [11:0] LENBUF_OFF   = 12'h154;        // length and buffer register
  localparam logic [2:0]  BUF_WIN      = 3'h3;           // paddr[11:9] of 0x600..0x7ff
  localparam int          WIN_LSB      = 9;              // low bit of window compare
  localparam int          BUF_SEL_POS  = 8;              // paddr bit picking buffer 1
  localparam int          WORD_LSB     = 2;              // word index starts here
  localparam int          SIG_POS      = 0;              // signalling type send
  localparam int          FCS_POS      = 1;              // checksum append enable
  localparam int          IDLE_POS     = 2;              // forced idle flags
  localparam int          ABORT_POS    = 3;              // abort pattern
  localparam int          SEL_POS      = 7;              // buffer select / free
  localparam logic [7:0]  CTRL_MASK    = 8'h0f;          // bits kept by this block
  localparam logic [7:0]  CTRL_RESET   = 8'h00;          // control reset value
  localparam logic [6:0]  COUNT_RESET  = 7'h00;          // count reset value
  localparam logic [7:0]  FLAG_OCTET   = 8'h7e;          // hdlc flag
  localparam logic [15:0] CRC_INIT     = 16'hffff;       // fcs preset
  localparam logic [15:0] CRC_POLY     = 16'h8408;       // reflected ccitt polynomial
  localparam logic [2:0]  STUFF_RUN    = 3'h5;           // ones before a stuffed zero
  localparam logic [3:0]  LAST_BIT     = 4'h7;           // bits left after first
  localparam logic [1:0]  FIFO_DEPTH   = 2'h2;           // two-entry data buffer

  // producer states
  typedef enum logic [2:0] {P_IDLE, P_OPEN, P_DATA, P_FCS_LO, P_FCS_HI, P_BOS_HI, P_BOS_LO} prod_state_t;

  // one octet of the lsb-first fcs
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] x;
    x = c;
    for (int i = 0; i < 8; i++) begin
      x = (x[0] ^ d[i]) ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction : crc_byte
endpackage : dl_tx_pkg

// ---- core/msg_mem.sv ----
// two message buffers in one word store, read data registered
// assumes a single clock shared with the controller
`timescale 1ns/1ps
module msg_mem #(
  parameter int AW    = 6,  // word address width
  parameter int DW    = 32, // word width
  parameter int DEPTH = 64  // words held
) (
  input wire logic  pclk,    // clock
  input wire logic  presetn, // async reset, active low
  msg_mem_if.store  mem      // store port
);
  if (DEPTH > (1 << AW) || DEPTH < 2) begin : g_chk
    $error("msg_mem depth does not fit the address");
  end

  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] words; // stored words
    logic [DW-1:0]            rdata; // read register
  } mem_state_t;

  mem_state_t r, next_r;

  // read first, read returns the old word on a clash
  always_comb begin
    next_r = r;
    next_r.rdata = r.words[mem.raddr];
    if (mem.we) begin
      next_r.words[mem.waddr] = mem.wdata;
    end
  end

  // contents clear at reset so reads never show unknowns
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign mem.rdata = r.rdata;
endmodule : msg_mem

// ---- core/msg_mem_if.sv ----
// write and read port of the message buffer store
// assumes the owner drives addresses and the store answers one cycle later
`timescale 1ns/1ps
interface msg_mem_if #(parameter int AW = 6, parameter int DW = 32);
  logic          we;     // write strobe
  logic [AW-1:0] waddr;  // write word address
  logic [DW-1:0] wdata;  // write word
  logic [AW-1:0] raddr;  // read word address
  logic [DW-1:0] rdata;  // registered read word
  modport owner (output we, waddr, wdata, raddr, input rdata);
  modport store (input we, waddr, wdata, raddr, output rdata);
endinterface : msg_mem_if

// ---- tb/datalink_hdlc_tx_control_tb.sv ----
// testbench: apb register calls and line checks for the data-link transmit controller
// assumes the far-end model decodes frames; the bench plays software on apb
`timescale 1ns/1ps
module datalink_hdlc_tx_control_tb import dl_tx_pkg::*; ;
  logic              pclk, presetn, psel, penable, pwrite, clr; // bench-driven inputs
  logic [ADDR_W-1:0] paddr;                                     // apb address
  logic [DATA_W-1:0] pwdata, prdata, rd;                        // apb data, last read
  logic              pready, pslverr, er, dl_slot, dl_bit, irq; // answers and line
  int                bad_count, compares, irqs, f0, i0;         // counters, snapshots
  logic [7:0]        msg [0:7] = '{8'hff, 8'h7e, 8'h3f, 8'hfc, 8'h81, 8'h00, 8'h00, 8'h00};
  logic [15:0]       fcs;                                       // expected checksum

  datalink_hdlc_tx_control u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dl_slot(dl_slot), .dl_bit(dl_bit), .tx_end_of_transfer_irq(irq));
  dl_far_end u_far (.pclk(pclk), .clr(clr), .dl_bit(dl_bit), .dl_slot(dl_slot));

  // 25 MHz clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // count end-of-transfer pulses
  always @(posedge pclk) if (irq === 1'b1) irqs++;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one apb transfer; holds the request until pready is sampled high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) bad_count++;
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rdchk
  task automatic slots(input int n);
    repeat (4 * n) @(posedge pclk);
  endtask : slots
  // clear the longest-run record in the far end
  task automatic clear();
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
  endtask : clear
  // bounded wait for the far end to close a new frame
  task automatic wait_frame();
    int n;
    n = 0;
    while (u_far.frame_count == f0 && n < 4000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 4000) bad_count++;
  endtask : wait_frame
  // own reflected crc-16, preset all ones, sent inverted
  function automatic logic [15:0] fcs_calc(input int n);
    logic [15:0] c;
    c = 16'hffff;
    for (int i = 0; i < n; i++)
      for (int j = 0; j < 8; j++) c = (c[0] ^ msg[i][j]) ? ((c >> 1) ^ 16'h8408) : (c >> 1);
    return ~c;
  endfunction : fcs_calc
  task automatic frame_chk(input int n, input logic add);
    check(32'(u_far.last_frame.size()), add ? 32'(n + 2) : 32'(n));
    for (int i = 0; i < n; i++) check({24'h0, u_far.last_frame[i]}, {24'h0, msg[i]});
    if (add) begin
      fcs = fcs_calc(n);
      check({24'h0, u_far.last_frame[n]}, {24'h0, fcs[7:0]});
      check({24'h0, u_far.last_frame[n+1]}, {24'h0, fcs[15:8]});
    end
  endtask : frame_chk
  task automatic test_done();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  // watchdog well beyond the roughly 4000 clocks the tests need
  initial begin
    #2000000;
    bad_count++;
    test_done();
  end

  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, clr} = 5'h0;
    paddr  = '0;
    pwdata = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(CTRL_OFF, 32'h0);
    rdchk(LENBUF_OFF, 32'h0);
    xfer(1'b0, 12'h100, 32'h0);
    check(32'(er), 32'h1);
    xfer(1'b1, CTRL_OFF, 32'h3);
    rdchk(CTRL_OFF, 32'h3);
    // nothing queued: only flags, no frames
    f0 = u_far.frame_count;
    i0 = u_far.flag_count;
    clear();
    slots(80);
    check(32'(u_far.max_ones), 32'h6);
    check(32'(u_far.flag_count - i0 >= 9), 32'h1);
    // framed message from buffer 0 with checksum; ones-rich payload forces stuffing
    for (int i = 0; i < 2; i++) xfer(1'b1, 12'h600 + 12'(4 * i), {msg[4*i+3], msg[4*i+2], msg[4*i+1], msg[4*i]});
    xfer(1'b1, LENBUF_OFF, 32'h05);
    rdchk(LENBUF_OFF, 32'h85);
    wait_frame();
    frame_chk(5, 1'b1);
    rdchk(LENBUF_OFF, 32'h05);
    // buffer 1, checksum off
    xfer(1'b1, CTRL_OFF, 32'h1);
    xfer(1'b1, 12'h700, {msg[3], msg[2], msg[1], msg[0]});
    f0 = u_far.frame_count;
    xfer(1'b1, LENBUF_OFF, 32'h83);
    wait_frame();
    frame_chk(3, 1'b0);
    // abort pattern; the paused line holds a frame queued meanwhile at its opening flag
    xfer(1'b1, CTRL_OFF, 32'h9);
    f0 = u_far.frame_count;
    clear();
    slots(20);
    check(32'(u_far.max_ones >= 7), 32'h1);
    xfer(1'b1, LENBUF_OFF, 32'h05);
    // forced idle drops that running frame, then a frame queued under it
    xfer(1'b1, CTRL_OFF, 32'h7);
    xfer(1'b1, LENBUF_OFF, 32'h05);
    slots(10);
    clear();
    slots(200);
    check(32'(u_far.frame_count), 32'(f0));
    check(32'(u_far.max_ones), 32'h6);
    xfer(1'b1, CTRL_OFF, 32'h1);
    // bit-oriented message of all ones, repeated three times, idle and checksum set
    xfer(1'b1, 12'h600, 32'h0000ffff);
    f0 = u_far.frame_count;
    xfer(1'b1, LENBUF_OFF, 32'h03);
    wait_frame();
    f0 = u_far.frame_count;
    i0 = irqs;
    clear();
    xfer(1'b1, CTRL_OFF, 32'h6);
    slots(150);
    check(32'(irqs - i0), 32'h1);
    check(32'(u_far.max_ones >= 16), 32'h1);
    check(32'(u_far.frame_count), 32'(f0));
    clear();
    slots(40);
    check(32'(u_far.max_ones), 32'h6);
    // zero count repeats without end
    xfer(1'b1, LENBUF_OFF, 32'h00);
    i0 = irqs;
    xfer(1'b1, CTRL_OFF, 32'h0);
    slots(200);
    check(32'(irqs - i0), 32'h0);
    clear();
    slots(40);
    check(32'(u_far.max_ones >= 16), 32'h1);
    test_done();
  end
endmodule : datalink_hdlc_tx_control_tb

// ---- tb/dl_far_end.sv ----
// far-end terminal model: paces dl_slot and decodes flags, stuffing and frames from dl_bit
// assumes dl_bit holds from the clock after a slot until the next slot
`timescale 1ns/1ps
module dl_far_end #(
  parameter int SLOT_DIV = 4 // clocks per data-link bit time
) (
  input  wire logic pclk,   // clock
  input  wire logic clr,    // clears the longest-run record
  input  wire logic dl_bit, // line bit from the controller
  output logic      dl_slot // bit time strobe
);
  int         div         = 0; // slot divider
  int         ones        = 0; // current run of ones
  int         nb          = 0; // bits in the partial octet
  int         max_ones    = 0; // longest run since clr
  int         flag_count  = 0; // flags seen
  int         frame_count = 0; // closed frames with content
  logic [7:0] acc;             // octet being built, lsb first
  logic [7:0] bytes_q [$];     // octets of the open frame
  logic [7:0] last_frame [$];  // octets of the last closed frame

  // shift one destuffed bit into the octet being built
  task automatic push(input logic b);
    acc = {b, acc[7:1]};
    nb++;
    if (nb == 8) begin
      bytes_q.push_back(acc);
      nb = 0;
    end
  endtask : push

  // free-running strobe, the way a framer's data-link bit timing runs
  assign dl_slot = (div == 0);

  // sample the bit held since the previous slot; a run of six ones then zero is a flag
  always @(posedge pclk) begin
    div <= (div == SLOT_DIV - 1) ? 0 : div + 1;
    if (clr) max_ones = 0;
    if (dl_slot) begin
      if (dl_bit === 1'b1) begin
        ones++;
        if (ones > max_ones) max_ones = ones;
        if (ones <= 5) push(1'b1);
      end else begin
        if (ones >= 6) begin // flag, or the end of an abort, which drops the frame
          if (ones == 6) flag_count++;
          if (ones == 6 && nb == 6 && bytes_q.size() > 0) begin
            last_frame = bytes_q;
            frame_count++;
          end
          bytes_q.delete();
          nb = 0;
        end else if (ones != 5) begin // a zero after five ones is stuffing
          push(1'b0);
        end
        ones = 0;
      end
    end
  end
endmodule : dl_far_end
